// ===== sopc_ctrl.sv
// serial output pin state control: decides open, low or read-back drive
// assumes mode, function select and count events come from logic on sys_clk_i;
// transfer select, serial clock and general-purpose pins arrive asynchronously
`timescale 1ns/1ps
`include "sopc_regs.svh"

module sopc_ctrl (
    input  wire logic                    sys_clk_i,
    input  wire logic                    sys_rst_i,
    input  wire logic                    xfer_select_pin_i,
    input  wire logic                    serial_clock_pin_i,
    input  wire sopc_pkg::sopc_mode_t    xfer_mode_i,
    input  wire logic [`SOPC_RB_W-1:0]   read_word_i,
    input  wire logic                    out_function_sel_b0_i,
    input  wire logic                    out_function_sel_b1_i,
    input  wire logic                    out_function_sel_b2_i,
    input  wire logic                    count_start_bit_i,
    input  wire logic                    count_finished_i,
    input  wire logic                    gpio1_pin_i,
    input  wire logic                    gpio1_is_output_i,
    input  wire logic                    gpio2_pin_i,
    input  wire logic                    gpio2_is_output_i,
    input  wire logic                    serial_out_pin_i,
    output logic                         serial_out_pin_o,
    output logic                         serial_out_pin_oe_n_o,
    output logic                         count_done_indication_o,
    output logic                         xfer_active_o,
    output logic                         serial_out_level_o
);

    // ****************************************
    // pin synchronisation
    // ****************************************
    logic [`SOPC_SYNC_W-1:0] pin_async;
    logic [`SOPC_SYNC_W-1:0] pin_lvl;
    logic [`SOPC_SYNC_W-1:0] pin_rise;
    logic [`SOPC_SYNC_W-1:0] pin_fall;

    assign pin_async = {serial_out_pin_i, gpio2_pin_i, gpio1_pin_i, serial_clock_pin_i, xfer_select_pin_i};

    sopc_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (pin_async),
        .level_o   (pin_lvl),
        .rise_o    (pin_rise),
        .fall_o    (pin_fall)
    );

    logic ce_rise;
    logic ce_fall;
    logic sclk_fall;

    assign ce_rise   = pin_rise[`SOPC_LN_CE];
    assign ce_fall   = pin_fall[`SOPC_LN_CE];
    assign sclk_fall = pin_fall[`SOPC_LN_SCLK];

    sopc_pkg::sopc_gpio_t gpio1;
    sopc_pkg::sopc_gpio_t gpio2;

    assign gpio1 = '{is_output: gpio1_is_output_i, level: pin_lvl[`SOPC_LN_IO1]};
    assign gpio2 = '{is_output: gpio2_is_output_i, level: pin_lvl[`SOPC_LN_IO2]};

    sopc_pkg::sopc_func_t fsel;

    assign fsel = sopc_pkg::sopc_func_t'({out_function_sel_b2_i, out_function_sel_b1_i, out_function_sel_b0_i});

    // ****************************************
    // helpers
    // ****************************************
    // open drain: pulling low is the only driven level
    function automatic sopc_pkg::sopc_pin_t od_drive(input logic pull_low);
        sopc_pkg::sopc_pin_t p;
        p.value = 1'b0;
        p.oe_n  = ~pull_low;
        return p;
    endfunction

    // a mirrored pin set as output cannot be echoed, so the line stays open
    function automatic logic gpio_pull(input sopc_pkg::sopc_gpio_t g);
        return ~g.is_output & ~g.level;
    endfunction

    // ****************************************
    // transfer state
    // ****************************************
    sopc_pkg::sopc_state_t st_r;
    sopc_pkg::sopc_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            sopc_pkg::SOPC_ST_IDLE: begin
                if (ce_rise) begin
                    case (xfer_mode_i)
                        sopc_pkg::SOPC_MODE_WR1: st_nxt = sopc_pkg::SOPC_ST_WRITE;
                        sopc_pkg::SOPC_MODE_WR2: st_nxt = sopc_pkg::SOPC_ST_WRITE;
                        sopc_pkg::SOPC_MODE_RD:  st_nxt = sopc_pkg::SOPC_ST_READ;
                        default:                 st_nxt = sopc_pkg::SOPC_ST_IDLE;
                    endcase
                end
            end
            sopc_pkg::SOPC_ST_WRITE: begin
                if (ce_fall) begin
                    st_nxt = sopc_pkg::SOPC_ST_IDLE;
                end
            end
            sopc_pkg::SOPC_ST_READ: begin
                if (ce_fall) begin
                    st_nxt = sopc_pkg::SOPC_ST_IDLE;
                end
            end
            default: begin
                st_nxt = sopc_pkg::SOPC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= sopc_pkg::SOPC_ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // read-back shifter
    // ****************************************
    logic [`SOPC_RB_W-1:0] shift_r;

    // first bit is presented from transfer select rise, the next on each clock fall
    // ones fill behind the word so surplus clocks leave the pin open
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            shift_r <= `SOPC_RST_RB;
        end else if (ce_rise && xfer_mode_i == sopc_pkg::SOPC_MODE_RD) begin
            shift_r <= read_word_i;
        end else if (st_r == sopc_pkg::SOPC_ST_READ && sclk_fall) begin
            shift_r <= {shift_r[`SOPC_RB_MSB-1:0], 1'b1};
        end
    end

    // ****************************************
    // count done indication
    // ****************************************
    logic done_r;
    logic start_prev_r;
    logic start_rise;

    assign start_rise = count_start_bit_i & ~start_prev_r;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            start_prev_r <= 1'b0;
        end else begin
            start_prev_r <= count_start_bit_i;
        end
    end

    // a finish in the same cycle as a clear is kept
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            done_r <= 1'b0;
        end else if (count_finished_i) begin
            done_r <= 1'b1;
        end else if (start_rise && fsel == sopc_pkg::SOPC_FN_DONE) begin
            done_r <= 1'b0;
        end else if (ce_rise) begin
            done_r <= 1'b0;
        end
    end

    // ****************************************
    // pin decision
    // ****************************************
    logic pull_nxt;

    always_comb begin
        pull_nxt = 1'b0;
        case (st_r)
            sopc_pkg::SOPC_ST_WRITE: begin
                pull_nxt = 1'b0;
            end
            sopc_pkg::SOPC_ST_READ: begin
                pull_nxt = ~shift_r[`SOPC_RB_MSB];
            end
            default: begin
                case (fsel)
                    sopc_pkg::SOPC_FN_LOW:  pull_nxt = 1'b1;
                    sopc_pkg::SOPC_FN_DONE: pull_nxt = done_r;
                    sopc_pkg::SOPC_FN_IO1:  pull_nxt = gpio_pull(gpio1);
                    sopc_pkg::SOPC_FN_IO2:  pull_nxt = gpio_pull(gpio2);
                    default:                pull_nxt = 1'b0;
                endcase
            end
        endcase
    end

    sopc_pkg::sopc_pin_t pin_r;

    // registered so the pin never glitches while the decision settles
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_r <= '{value: 1'b0, oe_n: 1'b1};
        end else begin
            pin_r <= od_drive(pull_nxt);
        end
    end

    assign serial_out_pin_o        = pin_r.value;
    assign serial_out_pin_oe_n_o   = pin_r.oe_n;
    assign count_done_indication_o = done_r;
    assign xfer_active_o           = (st_r != sopc_pkg::SOPC_ST_IDLE);
    assign serial_out_level_o      = pin_lvl[`SOPC_LN_PIN];

endmodule

// ===== sopc_ctrl_assertions.sv
// concurrent checks on the ports of the pin state control block
// assumes one clock domain and binding onto every sopc_ctrl
`timescale 1ns/1ps
module sopc_ctrl_checker (
    input wire logic                 sys_clk_i,
    input wire logic                 sys_rst_i,
    input wire logic                 serial_clock_pin_i,
    input wire sopc_pkg::sopc_mode_t xfer_mode_i,
    input wire logic                 out_function_sel_b0_i,
    input wire logic                 out_function_sel_b1_i,
    input wire logic                 out_function_sel_b2_i,
    input wire logic                 count_start_bit_i,
    input wire logic                 count_finished_i,
    input wire logic                 gpio1_is_output_i,
    input wire logic                 gpio2_is_output_i,
    input wire logic                 serial_out_pin_oe_n_o,
    input wire logic                 count_done_indication_o,
    input wire logic                 xfer_active_o
);
    logic [2:0] fs;
    logic       clk_q_r;
    logic [3:0] since_fall_r;
    assign fs = {out_function_sel_b2_i, out_function_sel_b1_i, out_function_sel_b0_i};
    // cycles since the raw serial clock fell; sync delay makes the bit move later
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clk_q_r <= 1'b0;
            since_fall_r <= 4'hf;
        end else begin
            clk_q_r <= serial_clock_pin_i;
            if (clk_q_r && !serial_clock_pin_i)
                since_fall_r <= 4'h0;
            else if (since_fall_r != 4'hf)
                since_fall_r <= since_fall_r + 4'h1;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_done_set: assert property (count_finished_i |=> count_done_indication_o)
        else $error("done flag missed a finish");
    a_done_low: assert property (fs == 3'h2 && count_done_indication_o && !xfer_active_o
        |=> !serial_out_pin_oe_n_o) else $error("pin not low on done");
    a_start_open: assert property (fs == 3'h2 && $rose(count_start_bit_i) && !count_finished_i
        && !xfer_active_o |=> !count_done_indication_o ##1 serial_out_pin_oe_n_o)
        else $error("count start did not release pin");
    a_xfer_clear: assert property ($rose(xfer_active_o) && !$past(count_finished_i)
        |-> !count_done_indication_o) else $error("transfer kept done flag");
    a_write_open: assert property (xfer_active_o && $past(xfer_active_o)
        && xfer_mode_i != sopc_pkg::SOPC_MODE_RD |-> serial_out_pin_oe_n_o)
        else $error("pin pulled during write");
    a_gpio_open: assert property ((fs == 3'h3 && gpio1_is_output_i || fs == 3'h4 && gpio2_is_output_i)
        && !xfer_active_o |=> serial_out_pin_oe_n_o) else $error("pin pulled for output gpio");
    a_fixed_open: assert property (!xfer_active_o && (fs == 3'h0 || fs > 3'h4)
        |=> serial_out_pin_oe_n_o) else $error("pin not open for select");
    a_fixed_low: assert property (!xfer_active_o && fs == 3'h1 |=> !serial_out_pin_oe_n_o)
        else $error("pin not low for select");
    a_read_step: assert property (xfer_active_o && $past(xfer_active_o, 2)
        && xfer_mode_i == sopc_pkg::SOPC_MODE_RD && $changed(serial_out_pin_oe_n_o)
        |-> since_fall_r inside {[1:7]}) else $error("read bit moved off clock");
endmodule
bind sopc_ctrl sopc_ctrl_checker u_sopc_ctrl_checker (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .serial_clock_pin_i(serial_clock_pin_i), .xfer_mode_i(xfer_mode_i),
    .out_function_sel_b0_i(out_function_sel_b0_i), .out_function_sel_b1_i(out_function_sel_b1_i),
    .out_function_sel_b2_i(out_function_sel_b2_i), .count_start_bit_i(count_start_bit_i),
    .count_finished_i(count_finished_i), .gpio1_is_output_i(gpio1_is_output_i),
    .gpio2_is_output_i(gpio2_is_output_i), .serial_out_pin_oe_n_o(serial_out_pin_oe_n_o),
    .count_done_indication_o(count_done_indication_o), .xfer_active_o(xfer_active_o));

// ===== sopc_ctrl_bench.sv
// self-checking bench for the pin state control block
// assumes sopc_host_model as the far side and the bound checker
`timescale 1ns/1ps
module sopc_ctrl_bench;
    logic                 sys_clk_i;
    logic                 sys_rst_i;
    sopc_pkg::sopc_mode_t mode;
    logic [23:0]          word;
    logic [2:0]           fs;
    logic                 start, fin, g, go;
    logic                 ce, sclk, lvl, pin_o, oe_n, done, act, lvl_o;
    logic [31:0]          rx;
    int                   error_cnt, n_tests;
    initial sys_clk_i = 1'b0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    sopc_ctrl u_sopc_ctrl (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .xfer_select_pin_i(ce),
        .serial_clock_pin_i(sclk), .xfer_mode_i(mode), .read_word_i(word), .out_function_sel_b0_i(fs[0]),
        .out_function_sel_b1_i(fs[1]), .out_function_sel_b2_i(fs[2]), .count_start_bit_i(start),
        .count_finished_i(fin), .gpio1_pin_i(g), .gpio1_is_output_i(go), .gpio2_pin_i(g),
        .gpio2_is_output_i(go), .serial_out_pin_i(lvl), .serial_out_pin_o(pin_o),
        .serial_out_pin_oe_n_o(oe_n), .count_done_indication_o(done), .xfer_active_o(act),
        .serial_out_level_o(lvl_o));
    sopc_host_model u_sopc_host_model (.pin_value_i(pin_o), .pin_oe_n_i(oe_n), .xfer_select_o(ce),
        .serial_clock_o(sclk), .pin_level_o(lvl), .rx_o(rx));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic xfer(input int n);
        u_sopc_host_model.frame(n);
        cyc(1);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        conclude();
    end
    initial begin
        sys_rst_i = 1'b1;
        mode = sopc_pkg::SOPC_MODE_NONE;
        word = 24'ha5c396;
        {fs, start, fin, g, go} = 7'h00;
        cyc(12);
        sys_rst_i = 1'b0;
        chk({pin_o, oe_n, done, act}, 32'h4);
        // select, gpio direction and gpio level swept together
        for (int i = 0; i < 32; i++) begin
            fs = i[4:2];
            go = i[1];
            g = i[0];
            if (fs != 3'h2) begin
                cyc(6);
                chk(oe_n, (fs == 3'h1 || (fs inside {3'h3, 3'h4} && i[1:0] == 2'h0)) ? 0 : 1);
            end
        end
        fs = 3'h2;
        fin = 1'b1;
        cyc(1);
        fin = 1'b0;
        chk(done, 1);
        cyc(1);
        chk(oe_n, 0);
        start = 1'b1;
        cyc(1);
        chk(done, 0);
        cyc(1);
        chk(oe_n, 1);
        start = 1'b0;
        fin = 1'b1;
        cyc(1);
        fin = 1'b0;
        mode = sopc_pkg::SOPC_MODE_WR1;
        xfer(8);
        chk(rx, 32'hff);
        chk(done, 0);
        chk(lvl_o, 1);
        fs = 3'h1;
        mode = sopc_pkg::SOPC_MODE_WR2;
        xfer(8);
        chk(rx, 32'hff);
        chk(oe_n, 0);
        chk(lvl_o, 0);
        mode = sopc_pkg::SOPC_MODE_RD;
        xfer(24);
        chk(rx, {8'h00, word});
        xfer(26);
        chk(rx, {6'h00, word, 2'h3});
        mode = sopc_pkg::SOPC_MODE_NONE;
        xfer(4);
        chk(rx, 32'h0);
        conclude();
    end
endmodule

// ===== sopc_host_model.sv
// system controller model: transfer select, serial clock, pin sampling
// assumes an open-drain data pin with a pull-up; clock idles low
`timescale 1ns/1ps
module sopc_host_model (
    input  wire logic   pin_value_i,
    input  wire logic   pin_oe_n_i,
    output logic        xfer_select_o,
    output logic        serial_clock_o,
    output logic        pin_level_o,
    output logic [31:0] rx_o
);
    // pull-up wins whenever the block lets go of the pin
    assign pin_level_o = pin_oe_n_i ? 1'b1 : pin_value_i;
    initial begin
        xfer_select_o = 1'b0;
        serial_clock_o = 1'b0;
        rx_o = 32'h0;
    end
    // sampled late in the high phase so the shifted bit has settled
    task automatic frame(input int n);
        xfer_select_o = 1'b1;
        rx_o = 32'h0;
        #200;
        for (int i = 0; i < n; i++) begin
            serial_clock_o = 1'b1;
            #100;
            rx_o = {rx_o[30:0], pin_level_o};
            serial_clock_o = 1'b0;
            #100;
        end
        xfer_select_o = 1'b0;
        #200;
    endtask
endmodule

// ===== sopc_pkg.sv
// types shared by the serial output pin state control block
// assumes sopc_regs.svh is available on the include path
package sopc_pkg;

    // ****************************************
    // transfer mode decoded by the serial address logic
    // ****************************************
    typedef enum logic [1:0] {
        SOPC_MODE_NONE = 2'h0,
        SOPC_MODE_WR1  = 2'h1,
        SOPC_MODE_WR2  = 2'h2,
        SOPC_MODE_RD   = 2'h3
    } sopc_mode_t;

    // ****************************************
    // output function select encodings
    // ****************************************
    typedef enum logic [2:0] {
        SOPC_FN_OPEN  = 3'h0,
        SOPC_FN_LOW   = 3'h1,
        SOPC_FN_DONE  = 3'h2,
        SOPC_FN_IO1   = 3'h3,
        SOPC_FN_IO2   = 3'h4,
        SOPC_FN_RSV5  = 3'h5,
        SOPC_FN_RSV6  = 3'h6,
        SOPC_FN_RSV7  = 3'h7
    } sopc_func_t;

    // ****************************************
    // transfer state
    // ****************************************
    typedef enum logic [1:0] {
        SOPC_ST_IDLE  = 2'h0,
        SOPC_ST_WRITE = 2'h1,
        SOPC_ST_READ  = 2'h2,
        SOPC_ST_SPARE = 2'h3
    } sopc_state_t;

    // open-drain pin drive: value is always low, oe_n low while pulling
    typedef struct packed {
        logic value;
        logic oe_n;
    } sopc_pin_t;

    // general-purpose pin view
    typedef struct packed {
        logic is_output;
        logic level;
    } sopc_gpio_t;

endpackage

// ===== sopc_regs.svh
// named constants for the serial output pin state control block
// assumes inclusion by bare name from every design file that needs it
`ifndef SOPC_REGS_SVH
`define SOPC_REGS_SVH

// ****************************************
// widths
// ****************************************
`define SOPC_FSEL_W      3
`define SOPC_RB_W        24
`define SOPC_SYNC_W      5

// ****************************************
// synchroniser lane positions
// ****************************************
`define SOPC_LN_CE       0
`define SOPC_LN_SCLK     1
`define SOPC_LN_IO1      2
`define SOPC_LN_IO2      3
`define SOPC_LN_PIN      4

// ****************************************
// reset values and counts
// ****************************************
`define SOPC_RST_SYNC    5'h00
`define SOPC_RST_RB      24'h000000
`define SOPC_RB_MSB      23

`endif

// ===== sopc_sync.sv
// two-stage synchroniser with edge pulses for the pins of the block
// assumes all lanes are asynchronous to sys_clk_i
`timescale 1ns/1ps
`include "sopc_regs.svh"
module sopc_sync (
    input  wire logic                      sys_clk_i,
    input  wire logic                      sys_rst_i,
    input  wire logic [`SOPC_SYNC_W-1:0]   async_i,
    output logic      [`SOPC_SYNC_W-1:0]   level_o,
    output logic      [`SOPC_SYNC_W-1:0]   rise_o,
    output logic      [`SOPC_SYNC_W-1:0]   fall_o
);

    logic [`SOPC_SYNC_W-1:0] meta_r;
    logic [`SOPC_SYNC_W-1:0] stab_r;
    logic [`SOPC_SYNC_W-1:0] prev_r;

    // meta_r is read only by stab_r
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_r <= `SOPC_RST_SYNC;
            stab_r <= `SOPC_RST_SYNC;
            prev_r <= `SOPC_RST_SYNC;
        end else begin
            meta_r <= async_i;
            stab_r <= meta_r;
            prev_r <= stab_r;
        end
    end

    assign level_o = stab_r;
    assign rise_o  = stab_r & ~prev_r;
    assign fall_o  = ~stab_r & prev_r;

endmodule
